/* rtl/xsd_decode.sv */
// Extended stack instruction decode and execute unit.
// Assumes the core presents each program word for a whole instruction
// cycle, serves data reads in the same clock as mem_re_o, and owns flags.
`timescale 1ns/1ps
`default_nettype none
module xsd_decode
  import xsd_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output var  logic [31:0]       wb_dat_o,
  output var  logic              wb_ack_o,
  // Program word from fetch
  input  wire logic [15:0]       instr_i,
  input  wire logic              instr_valid_i,
  input  wire logic              operand_use_i,
  input  wire logic [20:0]       ret_top_i,
  // Data memory
  input  wire logic [DATA_W-1:0] mem_rdata_i,
  output var  logic [ADDR_W-1:0] mem_addr_o,
  output var  logic [DATA_W-1:0] mem_wdata_o,
  output var  logic              mem_we_o,
  output var  logic              mem_re_o,
  // Core control
  output var  logic              pc_load_o,
  output var  logic [20:0]       pc_value_o,
  output var  logic [ADDR_W-1:0] op_addr_o,
  output var  logic              op_valid_o,
  output var  logic              op_to_wreg_o,
  output var  logic              flags_hold_o,
  output var  logic              word_absorbed_o
);
  // -----------------------------------------------------------------
  // Phase, state and decode
  // -----------------------------------------------------------------
  logic [3:0]        ph;
  xsd_state_e        state;
  logic [15:0]       ir;
  logic              ext_en;
  logic [3:0]        bank;
  logic [ADDR_W-1:0] fsp [NPTR];
  logic              k_move1, k_move2, k_push, k_sub, k_ret, k_std;
  logic [DATA_W-1:0] move_data;
  logic              drop_flag;
  logic [ADDR_W-1:0] sum7, sum8, std_addr;
  logic              dst_drop;
  logic              wb_req, wb_wr, drop_clr;
  logic              is_move1, is_push, is_sub, is_ret;

  xsd_phase u_phase (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .phase_o (ph)
  );

  // Frame pointer plus move offset, and plus operand offset
  xsd_offset_add #(.OFF_W(7)) u_add_move (
    .base_i (fsp[SEL_FRAME]),
    .off_i  (ir[6:0]),
    .sum_o  (sum7)
  );
  xsd_offset_add #(.OFF_W(8)) u_add_std (
    .base_i (fsp[SEL_FRAME]),
    .off_i  (ir[7:0]),
    .sum_o  (sum8)
  );

  assign is_move1 = ext_en && (instr_i[15:7] == OPC_MOVE_W1);
  assign is_push  = ext_en && (instr_i[15:8] == OPC_PUSH);
  assign is_sub   = ext_en && (instr_i[15:8] == OPC_SUB) && (instr_i[7:6] != SEL_RETURN);
  assign is_ret   = ext_en && (instr_i[15:8] == OPC_SUB) && (instr_i[7:6] == SEL_RETURN);

  // Decode phase: classify the word and step the sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state           <= ST_IDLE;
      ir              <= 16'h0000;
      k_move1         <= 1'b0;
      k_move2         <= 1'b0;
      k_push          <= 1'b0;
      k_sub           <= 1'b0;
      k_ret           <= 1'b0;
      k_std           <= 1'b0;
      flags_hold_o    <= 1'b0;
      word_absorbed_o <= 1'b0;
    end else if (ph[PH_Q1]) begin
      ir      <= instr_i;
      k_move1 <= 1'b0;
      k_move2 <= 1'b0;
      k_push  <= 1'b0;
      k_sub   <= 1'b0;
      k_ret   <= 1'b0;
      k_std   <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          k_move1         <= instr_valid_i && is_move1;
          k_push          <= instr_valid_i && is_push;
          k_sub           <= instr_valid_i && is_sub;
          k_ret           <= instr_valid_i && is_ret;
          k_std           <= instr_valid_i && operand_use_i && !(is_move1 || is_push || is_sub || is_ret);
          flags_hold_o    <= instr_valid_i && (is_move1 || is_push || is_sub || is_ret);
          word_absorbed_o <= 1'b0;
          if (instr_valid_i && is_move1) begin
            state <= ST_MOVE;
          end else if (instr_valid_i && is_ret) begin
            state <= ST_NOP;
          end
        end
        ST_MOVE: begin
          // A bad second word runs as a no-operation
          k_move2         <= instr_valid_i && (instr_i[15:12] == OPC_MOVE_W2);
          flags_hold_o    <= 1'b1;
          word_absorbed_o <= 1'b1;
          if (instr_valid_i) begin
            state <= ST_IDLE;
          end
        end
        ST_NOP: begin
          flags_hold_o    <= 1'b1;
          word_absorbed_o <= 1'b1;
          state           <= ST_IDLE;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Data memory access
  // -----------------------------------------------------------------
  assign dst_drop = xsd_is_locked(sum7) || xsd_is_indirect(sum7);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_addr_o  <= '0;
      mem_wdata_o <= '0;
      mem_we_o    <= 1'b0;
      mem_re_o    <= 1'b0;
    end else begin
      mem_we_o <= 1'b0;
      mem_re_o <= 1'b0;
      if (ph[PH_Q3]) begin
        if (k_move1) begin
          mem_re_o   <= 1'b1;
          mem_addr_o <= sum7;
        end else if (k_move2 && !dst_drop) begin
          mem_we_o    <= 1'b1;
          mem_addr_o  <= sum7;
          mem_wdata_o <= move_data;
        end else if (k_push) begin
          mem_we_o    <= 1'b1;
          mem_addr_o  <= fsp[SEL_FRAME];
          mem_wdata_o <= ir[7:0];
        end
      end
    end
  end

  // Source byte taken at the end of Q4 of the first cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      move_data <= '0;
    end else if (ph[PH_Q4] && k_move1) begin
      move_data <= xsd_is_indirect(mem_addr_o) ? '0 : mem_rdata_i;
    end
  end

  // -----------------------------------------------------------------
  // Pointers and return
  // -----------------------------------------------------------------
  // Software writes lose against a same-cycle hardware update
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NPTR; i++) begin
        fsp[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NPTR; i++) begin
        if (wb_wr && (wb_adr_i[7:2] == REG_PTR_BASE[7:2] + 6'(i))) begin
          if (wb_sel_i[0]) begin
            fsp[i][7:0] <= wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            fsp[i][11:8] <= wb_dat_i[11:8];
          end
        end
      end
      if (ph[PH_Q4]) begin
        if (k_push) begin
          fsp[SEL_FRAME] <= fsp[SEL_FRAME] - 12'h001;
        end else if (k_sub) begin
          fsp[ir[7:6]] <= fsp[ir[7:6]] - {6'h00, ir[5:0]};
        end else if (k_ret) begin
          fsp[SEL_FRAME] <= fsp[SEL_FRAME] - {6'h00, ir[5:0]};
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pc_load_o  <= 1'b0;
      pc_value_o <= '0;
    end else begin
      pc_load_o <= ph[PH_Q4] && k_ret;
      if (ph[PH_Q4] && k_ret) begin
        pc_value_o <= ret_top_i;
      end
    end
  end

  // -----------------------------------------------------------------
  // Operand resolution for standard instructions
  // -----------------------------------------------------------------
  always_comb begin
    if (ir[ACC_BIT]) begin
      std_addr = {bank, ir[7:0]};
    end else if (ext_en && (ir[7:0] <= ACC_LAST)) begin
      std_addr = sum8;
    end else if (ir[7:0] <= ACC_LAST) begin
      std_addr = {ACC_LOW_PG, ir[7:0]};
    end else begin
      std_addr = {ACC_HIGH_PG, ir[7:0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_addr_o    <= '0;
      op_valid_o   <= 1'b0;
      op_to_wreg_o <= 1'b0;
    end else if (ph[PH_Q1]) begin
      op_valid_o <= 1'b0;
    end else if (ph[PH_Q2] && k_std) begin
      op_addr_o    <= std_addr;
      op_valid_o   <= 1'b1;
      op_to_wreg_o <= !ir[DEST_BIT];
    end
  end

  // -----------------------------------------------------------------
  // Wishbone registers
  // -----------------------------------------------------------------
  assign wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr    = wb_req && wb_we_i;
  assign drop_clr = wb_wr && (wb_adr_i == REG_STAT) && wb_sel_i[0] && wb_dat_i[STAT_DROP];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_en <= EXT_RESET;
      bank   <= 4'h0;
    end else if (wb_wr && wb_sel_i[0]) begin
      if (wb_adr_i == REG_CTRL) begin
        ext_en <= wb_dat_i[CTRL_EXT_BIT];
      end
      if (wb_adr_i == REG_BANK) begin
        bank <= wb_dat_i[3:0];
      end
    end
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drop_flag <= 1'b0;
    end else if (ph[PH_Q3] && k_move2 && dst_drop) begin
      drop_flag <= 1'b1;
    end else if (drop_clr) begin
      drop_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= '0;
      if (wb_req && !wb_we_i) begin
        if (wb_adr_i == REG_CTRL) begin
          wb_dat_o[CTRL_EXT_BIT] <= ext_en;
        end else if (wb_adr_i == REG_STAT) begin
          wb_dat_o[STAT_DROP] <= drop_flag;
          wb_dat_o[2:0]       <= state;
        end else if (wb_adr_i == REG_BANK) begin
          wb_dat_o[3:0] <= bank;
        end else begin
          for (int i = 0; i < NPTR; i++) begin
            if (wb_adr_i[7:2] == REG_PTR_BASE[7:2] + 6'(i)) begin
              wb_dat_o[ADDR_W-1:0] <= fsp[i];
            end
          end
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  sequence s_ret_end;
    k_ret && ph[PH_Q4];
  endsequence
  sequence s_quiet4;
    (!mem_we_o && !mem_re_o)[*4];
  endsequence

  push_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    k_push && ph[PH_Q3] |=> mem_we_o && mem_addr_o == fsp[SEL_FRAME] && mem_wdata_o == ir[7:0])
    else $error("push write wrong");
  push_dec_a: assert property (@(posedge clk_i) disable iff (rst_i)
    k_push && ph[PH_Q4] && !wb_wr |=> fsp[SEL_FRAME] == $past(fsp[SEL_FRAME]) - 12'h001)
    else $error("push decrement wrong");
  move_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
    k_move1 && ph[PH_Q3] |=> mem_re_o && mem_addr_o == 12'(fsp[SEL_FRAME] + 12'(ir[6:0])))
    else $error("move source address wrong");
  move_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    k_move2 && ph[PH_Q3] && dst_drop |=> !mem_we_o)
    else $error("protected move write seen");
  sub_ptr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    k_sub && ph[PH_Q4] && !wb_wr |=> fsp[$past(ir[7:6])] == $past(fsp[ir[7:6]]) - 12'($past(ir[5:0])))
    else $error("pointer subtract wrong");
  ret_pc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_ret_end |=> pc_load_o && pc_value_o == $past(ret_top_i))
    else $error("return load wrong");
  ret_nop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_ret_end |=> s_quiet4 ##0 (state == ST_IDLE))
    else $error("return second cycle not idle");
  ext_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ph[PH_Q1] && !ext_en |=> !k_move1 && !k_push && !k_sub && !k_ret)
    else $error("extension ran while off");
  std_index_a: assert property (@(posedge clk_i) disable iff (rst_i)
    k_std && ph[PH_Q2] && ext_en && !ir[ACC_BIT] && ir[7:0] <= ACC_LAST
    |=> op_valid_o && op_addr_o == 12'(fsp[SEL_FRAME] + 12'(ir[7:0])))
    else $error("indexed operand wrong");
  move_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_we_o && k_move2 |-> ph[PH_Q4] && mem_wdata_o == move_data)
    else $error("move write misplaced");
endmodule : xsd_decode
`default_nettype wire

/* shared/xsd_pkg.sv */
// Constants, opcode patterns, register map and state codes of the
// extended stack instruction decoder.
// Assumes a 12-bit data address space and an 8-bit data path.
`default_nettype none
package xsd_pkg;
  // ---------------------------------------------------------------
  // Widths and phases
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int NPTR   = 3;
  localparam int PH_Q1  = 0;
  localparam int PH_Q2  = 1;
  localparam int PH_Q3  = 2;
  localparam int PH_Q4  = 3;
  localparam logic [3:0] PH_RESET = 4'h1;

  // ---------------------------------------------------------------
  // Opcode patterns
  // ---------------------------------------------------------------
  localparam logic [8:0] OPC_MOVE_W1 = 9'h1d7;  // 1110 1011 1
  localparam logic [3:0] OPC_MOVE_W2 = 4'hf;
  localparam logic [7:0] OPC_PUSH    = 8'hea;
  localparam logic [7:0] OPC_SUB     = 8'he9;
  localparam logic [1:0] SEL_RETURN  = 2'h3;
  localparam logic [1:0] SEL_FRAME   = 2'h2;
  localparam logic [7:0] ACC_LAST    = 8'h5f;
  localparam logic [3:0] ACC_LOW_PG  = 4'h0;
  localparam logic [3:0] ACC_HIGH_PG = 4'hf;
  localparam int         ACC_BIT     = 8;
  localparam int         DEST_BIT    = 9;

  // ---------------------------------------------------------------
  // Special data addresses (placement arbitrary)
  // ---------------------------------------------------------------
  localparam logic [11:0] PC_LOW_ADDR = 12'hff9;
  localparam logic [11:0] TOP_U_ADDR  = 12'hfff;
  localparam logic [11:0] TOP_H_ADDR  = 12'hffe;
  localparam logic [11:0] TOP_L_ADDR  = 12'hffd;
  localparam logic [11:0] IND_FIRST   = 12'hfd9;
  localparam logic [11:0] IND_LAST    = 12'hfef;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STAT     = 8'h04;
  localparam logic [7:0] REG_PTR_BASE = 8'h08;
  localparam logic [7:0] REG_BANK     = 8'h14;
  localparam int         CTRL_EXT_BIT = 0;
  localparam int         STAT_DROP    = 4;
  localparam logic       EXT_RESET    = 1'b0;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_MOVE = 3'b010,
    ST_NOP  = 3'b100
  } xsd_state_e;

  function automatic logic xsd_is_indirect(input logic [11:0] a);
    return (a >= IND_FIRST) && (a <= IND_LAST);
  endfunction : xsd_is_indirect

  function automatic logic xsd_is_locked(input logic [11:0] a);
    return (a == PC_LOW_ADDR) || (a == TOP_U_ADDR) || (a == TOP_H_ADDR) || (a == TOP_L_ADDR);
  endfunction : xsd_is_locked
endpackage : xsd_pkg
`default_nettype wire

/* rtl/xsd_phase.sv */
// Four-phase instruction cycle sequencer, one clock per phase.
// Assumes a synchronous active-high reset shared with the core.
`timescale 1ns/1ps
`default_nettype none
module xsd_phase
  import xsd_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // One-hot phase, bit 0 is the decode phase
  output var  logic [3:0] phase_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_o <= PH_RESET;
    end else begin
      phase_o <= {phase_o[2:0], phase_o[3]};
    end
  end
endmodule : xsd_phase
`default_nettype wire

/* rtl/xsd_offset_add.sv */
// Adds an unsigned offset to a data address; wraps inside the space.
// Assumes OFF_W is narrower than the address.
`timescale 1ns/1ps
`default_nettype none
module xsd_offset_add
  import xsd_pkg::*;
#(
  parameter int OFF_W = 7
) (
  // Operands
  input  wire logic [ADDR_W-1:0] base_i,
  input  wire logic [OFF_W-1:0]  off_i,
  // Result
  output wire logic [ADDR_W-1:0] sum_o
);
  assign sum_o = base_i + {{(ADDR_W-OFF_W){1'b0}}, off_i};
endmodule : xsd_offset_add
`default_nettype wire

/* testbench/xsd_decode_test.sv */
// Self-checking bench for the extended stack instruction decoder.
// Assumes xsd_pkg is compiled first; the bench plays core, fetch and data memory.
`timescale 1ns/1ps
`default_nettype none
module xsd_decode_test
  import xsd_pkg::*;
();
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]        adr = 8'h00;
  logic [3:0]        sel = 4'h0;
  logic [31:0]       wdat = 32'h0, rdat;
  logic              ack, mem_we, mem_re, pc_load, op_valid, to_wreg, hold;
  logic [15:0]       instr = 16'h0;
  logic              valid = 1'b0, opu = 1'b0;
  logic [20:0]       ret_top = 21'h0, pc_value;
  logic [DATA_W-1:0] mem_rdata = 8'h00, mem_wdata;
  logic [ADDR_W-1:0] mem_addr, op_addr;
  logic              absorbed;
  logic [1:0]        ph;
  integer            seed, miscompares = 0, n_checks = 0;
  int                n_wr, n_rd, n_pc, n_hold, n_abs, wr_ph, rd_ph;
  logic [11:0]       wr_addr, rd_addr, op_seen;
  logic [7:0]        wr_data;
  logic [20:0]       pc_seen;
  logic              wreg_seen;

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  xsd_decode xsd_decode_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .instr_i(instr),
    .instr_valid_i(valid), .operand_use_i(opu), .ret_top_i(ret_top), .mem_rdata_i(mem_rdata),
    .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_we_o(mem_we), .mem_re_o(mem_re),
    .pc_load_o(pc_load), .pc_value_o(pc_value), .op_addr_o(op_addr), .op_valid_o(op_valid),
    .op_to_wreg_o(to_wreg), .flags_hold_o(hold), .word_absorbed_o(absorbed));

  // ---------------------------------------------------------------
  // Phase tracking and output monitor
  // ---------------------------------------------------------------
  // Clock after the last reset edge is Q1, so ph 0..3 mirrors Q1..Q4
  always @(posedge clk_i) ph <= rst_i ? 2'd0 : ph + 2'd1;

  always @(posedge clk_i) begin
    if (mem_we === 1'b1) begin
      n_wr++; wr_addr = mem_addr; wr_data = mem_wdata; wr_ph = ph;
    end
    if (mem_re === 1'b1) begin
      n_rd++; rd_addr = mem_addr; rd_ph = ph;
    end
    if (pc_load === 1'b1) begin
      n_pc++; pc_seen = pc_value;
    end
    if (hold === 1'b1) n_hold++;
    if (absorbed === 1'b1) n_abs++;
    if (op_valid === 1'b1) begin
      op_seen = op_addr; wreg_seen = to_wreg;
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Classic single Wishbone cycle; waits for ack, then one idle clock
  // No own limit: a missing ack is left to the watchdog
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'h3; wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk_i);
  endtask : wb_xfer

  task automatic wr(input logic [7:0] a, input logic [11:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, a, {20'h0, d}, q);
  endtask : wr

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [11:0] exp);
    logic [31:0] q;
    wb_xfer(1'b0, a, 32'h0, q);
    check(name, q, {20'h0, exp});
  endtask : rd_chk

  // Presents one word for a whole instruction cycle, starting at Q1
  task automatic word(input logic v, input logic [15:0] w, input logic u);
    do @(posedge clk_i); while (ph != 2'd3);
    valid <= v; instr <= w; opu <= u;
  endtask : word

  // Runs one or two words, then two idle cycles so late outputs land
  task automatic run(input logic [15:0] w1, input logic two, input logic [15:0] w2, input logic u);
    n_wr = 0; n_rd = 0; n_pc = 0; n_hold = 0; op_seen = 12'hx;
    n_abs = 0;
    word(1'b1, w1, u);
    if (two) word(1'b1, w2, 1'b0);
    word(1'b0, 16'($random(seed)), 1'b0);
    word(1'b0, 16'($random(seed)), 1'b0);
  endtask : run

  function automatic logic [11:0] exp_op(input logic ext, input logic [11:0] p, input logic [3:0] bank,
                                         input logic a, input logic [7:0] f);
    if (ext && !a && f <= ACC_LAST) return p + {4'h0, f};
    if (!a) return {(f <= ACC_LAST) ? ACC_LOW_PG : ACC_HIGH_PG, f};
    return {bank, f};
  endfunction : exp_op

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // ---------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------
  // Whole sequence needs under a thousand clocks; this leaves wide margin
  initial begin
    repeat (30000) @(posedge clk_i);
    miscompares++;
    complete_run();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [11:0] p, pv [3], ms [6], mz [6], md [6];
    logic [7:0]  k, f;
    logic [5:0]  s;
    logic        a, d, ext;
    logic [3:0]  bank;
    seed = 75;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("ctrl reset", REG_CTRL, 12'h000);
    rd_chk("unmapped", 8'hfc, 12'h000);
    // Extended push must do nothing while disabled
    p = 12'($random(seed));
    wr(REG_PTR_BASE + 8'h08, p);
    run({OPC_PUSH, 8'h5a}, 1'b0, 16'h0, 1'b0);
    check("push off writes", n_wr, 0);
    check("push off hold", n_hold, 0);
    rd_chk("push off ptr", REG_PTR_BASE + 8'h08, p);
    $display("disabled test done");
    wr(REG_CTRL, 12'h001);
    // Literal push, including pointer wrap below zero
    for (int i = 0; i < 4; i++) begin
      p = (i == 0) ? 12'h000 : 12'($random(seed));
      k = 8'($random(seed));
      wr(REG_PTR_BASE + 8'h08, p);
      run({OPC_PUSH, k}, 1'b0, 16'h0, 1'b0);
      check("push writes", n_wr, 1);
      check("push addr", wr_addr, p);
      check("push data", wr_data, k);
      check("push hold", n_hold > 0, 1);
      rd_chk("push ptr", REG_PTR_BASE + 8'h08, p - 12'h001);
    end
    $display("push test done");
    // Subtract from each pointer; selector 11 returns and eats the next word
    for (int fs = 0; fs < 4; fs++) begin
      for (int j = 0; j < 3; j++) begin
        pv[j] = 12'($random(seed));
        wr(REG_PTR_BASE + 8'(4 * j), pv[j]);
      end
      s = 6'($random(seed));
      ret_top <= 21'($random(seed));
      run({OPC_SUB, 2'(fs), s}, fs == 3, {OPC_PUSH, 8'h33}, 1'b0);
      pv[(fs == 3) ? 2 : fs] = pv[(fs == 3) ? 2 : fs] - {6'h0, s};
      for (int j = 0; j < 3; j++) rd_chk("sub ptr", REG_PTR_BASE + 8'(4 * j), pv[j]);
      check("sub pc loads", n_pc, (fs == 3) ? 1 : 0);
      if (fs == 3) check("return pc", pc_seen, ret_top);
      check("sub mem writes", n_wr, 0);
      check("sub hold", n_hold > 0, 1);
      check("sub absorbed", n_abs, (fs == 3) ? 4 : 0);
    end
    $display("subtract test done");
    // Move cases: random, wrap, indirect source, locked and indirect dest
    ms = '{12'h000, 12'hff0, IND_FIRST, 12'hf80, 12'hf80, 12'hf80};
    mz = '{12'h000, 12'h07f, 12'h000, 12'h001, 12'h002, 12'h003};
    md = '{12'h000, 12'h010, 12'h07f, PC_LOW_ADDR - 12'hf80, IND_LAST - 12'hf80, TOP_U_ADDR - 12'hf80};
    for (int c = 0; c < 6; c++) begin
      p = (c == 0) ? 12'($random(seed)) & 12'h7ff : ms[c];
      if (c == 0) mz[0] = 12'($random(seed)) & 12'h07f;
      if (c == 0) md[0] = 12'($random(seed)) & 12'h07f;
      k = 8'($random(seed));
      mem_rdata <= k;
      wr(REG_PTR_BASE + 8'h08, p);
      run({OPC_MOVE_W1, mz[c][6:0]}, 1'b1, {OPC_MOVE_W2, 5'($random(seed)), md[c][6:0]}, 1'b0);
      check("move reads", n_rd, 1);
      check("move src addr", rd_addr, 12'(p + mz[c]));
      check("move read phase", rd_ph, PH_Q4);
      check("move hold", n_hold > 0, 1);
      check("move absorbed", n_abs, 4);
      if (c >= 3) begin
        check("move blocked", n_wr, 0);
      end else begin
        check("move writes", n_wr, 1);
        check("move dst addr", wr_addr, 12'(p + md[c]));
        check("move data", wr_data, (c == 2) ? 8'h00 : k);
        check("move write phase", wr_ph, PH_Q4);
      end
      // Sticky drop flag, then cleared by writing one
      rd_chk("move drop flag", REG_STAT, {7'h0, c >= 3, 1'b0, ST_IDLE});
      if (c >= 3) wr(REG_STAT, 12'h010);
    end
    $display("move test done");
    // Standard operand resolution, enabled corners first, then disabled
    for (int i = 0; i < 8; i++) begin
      ext = (i < 5);
      f = (i == 0) ? ACC_LAST : (i == 1) ? 8'h60 : (i == 2) ? 8'($random(seed)) & ACC_LAST : 8'($random(seed));
      p = (i == 2) ? 12'h000 : 12'($random(seed));
      a = (i < 3) ? 1'b0 : 1'($random(seed));
      d = 1'($random(seed));
      bank = 4'($random(seed));
      wr(REG_CTRL, {11'h0, ext});
      wr(REG_PTR_BASE + 8'h08, p);
      wr(REG_BANK, {8'h0, bank});
      run({6'h09, d, a, f}, 1'b0, 16'h0, 1'b1);
      check("operand addr", op_seen, exp_op(ext, p, bank, a, f));
      check("operand dest", wreg_seen, !d);
    end
    $display("operand test done");
    complete_run();
  end
endmodule : xsd_decode_test
`default_nettype wire
